// file: logic/core_status_flag_register.sv
// Core status flag register with bank address forming and bus access.
//
// Decided for this implementation: the Avalon-MM register port.
`include "core_status_params.svh"

// Overview of operation
// - Any instruction except NOP, watchdog clear and sleep may write the status register.
// - Flag-updating instructions cannot write the three flags.
// - Expiry and power-down flags ignore every write.
// - File clear gives 000u u1uu on status.
// - Bit 7 selects indirect bank pair.
// - Bits 6:5 select the direct bank.
// - Direct address is bank bits plus 7-bit offset; indirect is bit 7 plus 8-bit pointer.
// - Watchdog clear or sleep sets expiry flag.
// - Watchdog clear sets, sleep clears power-down flag.
// - Zero flag marks a zero result.
// - Nibble flag is carry out of bit 3.
// - Subtract adds complement; carries are inverted borrows.
// - Rotates load the bit shifted out.
// - Status decodes at all four bank mirrors.
module core_status_flag_register
   import core_status_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input instr_req_t instr,
   input wire logic watchdog_timeout,
   input wire logic [6:0] direct_offset,
   input wire logic [7:0] indirect_pointer,
   output instr_rsp_t rsp,
   output logic [7:0] status_out,
   output logic [8:0] direct_addr,
   output logic [8:0] indirect_addr,
   output logic irq
);

   typedef struct packed {
      logic [7:0] status;
      logic [`EV_COUNT-1:0] irq_pend;
      logic [`EV_COUNT-1:0] irq_mask;
      logic bus_ack;
      logic [31:0] rdata;
      instr_rsp_t rsp;
      logic [8:0] direct_addr;
      logic [8:0] indirect_addr;
   } core_state_t;

   core_state_t q;
   core_state_t d;
   alu_out_t alu;

   logic bus_req;
   logic bus_commit;
   logic [3:0] word_idx;
   logic status_hit;
   logic flags_locked;
   logic [7:0] st;
   logic [`EV_COUNT-1:0] ev;
   logic [`EV_COUNT-1:0] read_clear;

   flag_alu u_flag_alu (
      .op(instr.op),
      .f_operand(instr.f_operand),
      .w_operand(instr.w_operand),
      .bit_sel(instr.bit_sel),
      .carry_in(q.status[`ST_MSB_OVF]),
      .res(alu)
   );

   // A request is answered one cycle after it is first seen; the commit
   // cycle is the one in which waitrequest is low.
   assign bus_req = (avs_read | avs_write) & ~q.bus_ack;
   assign bus_commit = (avs_read | avs_write) & q.bus_ack;
   assign avs_waitrequest = bus_req;
   assign word_idx = 4'(avs_address);

   always_comb begin
      d = q;
      ev = '0;
      read_clear = '0;
      st = q.status;
      status_hit = 1'b0;
      flags_locked = 1'b0;
      d.bus_ack = bus_req;
      d.rsp.valid = 1'b0;

      if (instr.valid) begin
         d.rsp.valid = 1'b1;
         d.rsp.data = alu.data;
         // Only the in-bank offset is compared, so every bank mirror hits.
         status_hit = alu.wr_dest & instr.dest_file
            & (instr.file_addr[6:0] == `STATUS_BANK_OFFSET);
         flags_locked = alu.upd_zero | alu.upd_nibble_ovf
            | alu.upd_msb_ovf;
         if (status_hit) begin
            st[7:5] = alu.data[7:5];
            if (!flags_locked) begin
               st[2:0] = alu.data[2:0];
            end else begin
               ev[`EV_FLAG_WRITE_DROPPED] = 1'b1;
            end
         end
         // Flag logic writes after the data path so that it wins.
         if (alu.upd_zero) begin
            st[`ST_ZERO] = alu.zero;
         end
         if (alu.upd_nibble_ovf) begin
            st[`ST_NIBBLE_OVF] = alu.nibble_ovf;
         end
         if (alu.upd_msb_ovf) begin
            st[`ST_MSB_OVF] = alu.msb_ovf;
         end
         case (instr.op)
            OP_WATCHDOG_CLEAR: begin
               st[`ST_WATCHDOG_EXPIRY] = 1'b1;
               st[`ST_POWERDOWN] = 1'b1;
               ev[`EV_WATCHDOG_CLEAR] = 1'b1;
            end
            OP_SLEEP: begin
               st[`ST_WATCHDOG_EXPIRY] = 1'b1;
               st[`ST_POWERDOWN] = 1'b0;
               ev[`EV_SLEEP] = 1'b1;
            end
            default: begin
            end
         endcase
      end else if (bus_commit && avs_write && avs_byteenable[0]
            && word_idx == `REG_STATUS_IDX) begin
         // A bus write behaves like a move to file: the reset-cause
         // bits stay untouched. It yields to a same-cycle instruction.
         st[7:5] = avs_writedata[7:5];
         st[2:0] = avs_writedata[2:0];
      end

      // The time-out is applied last so it is never lost to an
      // instruction in the same cycle.
      if (watchdog_timeout) begin
         st[`ST_WATCHDOG_EXPIRY] = 1'b0;
         ev[`EV_WATCHDOG_TIMEOUT] = 1'b1;
      end
      d.status = st;

      // Forming addresses from the bank bits and the in-bank offset or the indirect pointer.
      d.direct_addr = {st[`ST_DIRECT_BANK_HI:`ST_DIRECT_BANK_LO],
         direct_offset};
      d.indirect_addr = {st[`ST_INDIRECT_BANK], indirect_pointer};

      if (bus_commit && avs_write && avs_byteenable[0]
            && word_idx == `REG_IRQ_MASK_IDX) begin
         d.irq_mask = avs_writedata[`EV_COUNT-1:0];
      end

      // Only the bits that were returned are cleared, and a new event in
      // the same cycle still sets its bit.
      if (bus_commit && avs_read && word_idx == `REG_IRQ_STATUS_IDX) begin
         read_clear = q.rdata[`EV_COUNT-1:0];
      end
      d.irq_pend = (q.irq_pend & ~read_clear) | ev;

      if (bus_req && avs_read) begin
         case (word_idx)
            `REG_STATUS_IDX: d.rdata = {24'h00_0000, q.status};
            `REG_IRQ_STATUS_IDX:
               d.rdata = {28'h000_0000, q.irq_pend | ev};
            `REG_IRQ_MASK_IDX: d.rdata = {28'h000_0000, q.irq_mask};
            `REG_LAST_RESULT_IDX:
               d.rdata = {23'h00_0000, q.rsp.valid, q.rsp.data};
            default: d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         q.status <= `STATUS_RESET;
         q.irq_pend <= '0;
         q.irq_mask <= `IRQ_MASK_RESET;
         q.bus_ack <= 1'b0;
         q.rdata <= 32'h0000_0000;
         q.rsp <= '0;
         q.direct_addr <= 9'h000;
         q.indirect_addr <= 9'h000;
      end else begin
         q <= d;
      end
   end

   assign avs_readdata = q.rdata;
   assign rsp = q.rsp;
   assign status_out = q.status;
   assign direct_addr = q.direct_addr;
   assign indirect_addr = q.indirect_addr;
   assign irq = |(q.irq_pend & q.irq_mask);

endmodule : core_status_flag_register

// file: logic/core_status_params.svh
// Register offsets, status bit positions, reset values and event bits.
`ifndef CORE_STATUS_PARAMS_SVH
`define CORE_STATUS_PARAMS_SVH

// Word indices on the register bus.
`define REG_STATUS_IDX 4'h3
`define REG_IRQ_STATUS_IDX 4'h4
`define REG_IRQ_MASK_IDX 4'h5
`define REG_LAST_RESULT_IDX 4'h6

// In-bank offset at which the status register decodes in every bank.
`define STATUS_BANK_OFFSET 7'h03

// Status bit positions.
`define ST_INDIRECT_BANK 7
`define ST_DIRECT_BANK_HI 6
`define ST_DIRECT_BANK_LO 5
`define ST_WATCHDOG_EXPIRY 4
`define ST_POWERDOWN 3
`define ST_ZERO 2
`define ST_NIBBLE_OVF 1
`define ST_MSB_OVF 0

// Power-up value: expiry and power-down set, all other bits clear.
`define STATUS_RESET 8'h18
`define IRQ_MASK_RESET 4'h0

// Interrupt event bits.
`define EV_WATCHDOG_TIMEOUT 0
`define EV_SLEEP 1
`define EV_WATCHDOG_CLEAR 2
`define EV_FLAG_WRITE_DROPPED 3
`define EV_COUNT 4

`endif

// file: logic/core_status_pkg.sv
// Types shared by the status flag register and its flag ALU.
package core_status_pkg;

   typedef enum logic [4:0] {
      OP_NOP,
      OP_ADD,
      OP_SUB,
      OP_AND,
      OP_IOR,
      OP_XOR,
      OP_MOVF,
      OP_CLR,
      OP_COM,
      OP_INC,
      OP_DEC,
      OP_ROTATE_RIGHT,
      OP_ROTATE_LEFT,
      OP_SWAP,
      OP_BIT_CLEAR,
      OP_BIT_SET,
      OP_MOVE_W,
      OP_WATCHDOG_CLEAR,
      OP_SLEEP
   } alu_op_t;

   typedef struct packed {
      logic valid;
      alu_op_t op;
      logic [7:0] f_operand;
      logic [7:0] w_operand;
      logic [2:0] bit_sel;
      logic dest_file;
      logic [8:0] file_addr;
   } instr_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } instr_rsp_t;

   typedef struct packed {
      logic [7:0] data;
      logic zero;
      logic nibble_ovf;
      logic msb_ovf;
      logic upd_zero;
      logic upd_nibble_ovf;
      logic upd_msb_ovf;
      logic wr_dest;
   } alu_out_t;

endpackage : core_status_pkg

// file: logic/flag_alu.sv
// Combinational ALU that forms an instruction's result and its flags.
module flag_alu
   import core_status_pkg::*;
(
   input alu_op_t op,
   input wire logic [7:0] f_operand,
   input wire logic [7:0] w_operand,
   input wire logic [2:0] bit_sel,
   input wire logic carry_in,
   output alu_out_t res
);

   logic [8:0] sum9;
   logic [4:0] low5;
   logic [7:0] bit_mask;

   always_comb begin
      sum9 = 9'h000;
      low5 = 5'h00;
      bit_mask = 8'h01 << bit_sel;
      res = '0;
      res.wr_dest = 1'b1;
      case (op)
         OP_ADD: begin
            sum9 = {1'b0, f_operand} + {1'b0, w_operand};
            low5 = {1'b0, f_operand[3:0]} + {1'b0, w_operand[3:0]};
            res.upd_nibble_ovf = 1'b1;
            res.upd_msb_ovf = 1'b1;
            res.upd_zero = 1'b1;
         end
         OP_SUB: begin
            // Adding the complement plus one makes both carries read as
            // inverted borrows without a separate borrow chain.
            sum9 = {1'b0, f_operand} + {1'b0, ~w_operand} + 9'h001;
            low5 = {1'b0, f_operand[3:0]} + {1'b0, ~w_operand[3:0]}
               + 5'h01;
            res.upd_nibble_ovf = 1'b1;
            res.upd_msb_ovf = 1'b1;
            res.upd_zero = 1'b1;
         end
         OP_AND: begin
            sum9 = {1'b0, f_operand & w_operand};
            res.upd_zero = 1'b1;
         end
         OP_IOR: begin
            sum9 = {1'b0, f_operand | w_operand};
            res.upd_zero = 1'b1;
         end
         OP_XOR: begin
            sum9 = {1'b0, f_operand ^ w_operand};
            res.upd_zero = 1'b1;
         end
         OP_MOVF: begin
            sum9 = {1'b0, f_operand};
            res.upd_zero = 1'b1;
         end
         OP_CLR: begin
            sum9 = 9'h000;
            res.upd_zero = 1'b1;
         end
         OP_COM: begin
            sum9 = {1'b0, ~f_operand};
            res.upd_zero = 1'b1;
         end
         OP_INC: begin
            sum9 = {1'b0, f_operand} + 9'h001;
            res.upd_zero = 1'b1;
         end
         OP_DEC: begin
            sum9 = {1'b0, f_operand} - 9'h001;
            res.upd_zero = 1'b1;
         end
         OP_ROTATE_RIGHT: begin
            sum9 = {f_operand[0], carry_in, f_operand[7:1]};
            res.upd_msb_ovf = 1'b1;
         end
         OP_ROTATE_LEFT: begin
            sum9 = {f_operand[7], f_operand[6:0], carry_in};
            res.upd_msb_ovf = 1'b1;
         end
         OP_SWAP: sum9 = {1'b0, f_operand[3:0], f_operand[7:4]};
         OP_BIT_CLEAR: sum9 = {1'b0, f_operand & ~bit_mask};
         OP_BIT_SET: sum9 = {1'b0, f_operand | bit_mask};
         OP_MOVE_W: sum9 = {1'b0, w_operand};
         default: res.wr_dest = 1'b0;
      endcase
      res.data = sum9[7:0];
      res.zero = (sum9[7:0] == 8'h00);
      res.nibble_ovf = low5[4];
      res.msb_ovf = sum9[8];
   end

endmodule : flag_alu

// file: tb/core_exec_model.sv
// Behavioural model of the instruction execution logic beside the block.
module core_exec_model
   import core_status_pkg::*;
(
   input wire logic mclk,
   output instr_req_t instr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial instr = '0;
   // Status is normally altered only with the safe ops; a test may differ.
   task automatic issue(input alu_op_t op, input logic [7:0] f,
         input logic [7:0] w, input logic [2:0] bs, input logic dst,
         input logic [8:0] addr);
      @(posedge mclk);
      instr <= '{1'b1, op, f, w, bs, dst, addr};
      @(posedge mclk);
      instr.valid <= 1'b0;
      @(negedge mclk);
   endtask : issue
endmodule : core_exec_model

// file: tb/core_status_flag_register_props.sv
// Port-level checker for the core status flag register.
module core_status_flag_register_props
   import core_status_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input instr_req_t instr,
   input wire logic watchdog_timeout,
   input wire logic [6:0] direct_offset,
   input wire logic [7:0] indirect_pointer,
   input instr_rsp_t rsp,
   input wire logic [7:0] status_out,
   input wire logic [8:0] direct_addr,
   input wire logic [8:0] indirect_addr,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic is_sub;
   logic is_watchdog_clear;
   logic rot_out;
   logic [8:0] sum9;
   logic [4:0] nib5;
   // Subtraction is modelled as f plus the inverted w plus one.
   assign is_sub = instr.op == OP_SUB;
   assign is_watchdog_clear = instr.op == OP_WATCHDOG_CLEAR;
   assign rot_out = instr.op == OP_ROTATE_RIGHT ? instr.f_operand[0]
                                                : instr.f_operand[7];
   assign sum9 = {1'b0, instr.f_operand}
      + {1'b0, is_sub ? ~instr.w_operand : instr.w_operand} + {8'h00, is_sub};
   assign nib5 = {1'b0, instr.f_operand[3:0]}
      + {1'b0, is_sub ? ~instr.w_operand[3:0] : instr.w_operand[3:0]}
      + {4'h0, is_sub};
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus wait exceeds one cycle");
   AST_EXPIRY_CLEAR: assert property (
      watchdog_timeout |=> !status_out[4])
      else $error("expiry flag not cleared by time-out");
   AST_CAUSE_SET: assert property (
      instr.valid && instr.op inside {OP_WATCHDOG_CLEAR, OP_SLEEP}
      && !watchdog_timeout
      |=> status_out[4:3] == {1'b1, $past(is_watchdog_clear)})
      else $error("expiry or power-down flag wrong after event");
   AST_CAUSE_HOLD: assert property (!watchdog_timeout &&
      !(instr.valid && instr.op inside {OP_WATCHDOG_CLEAR, OP_SLEEP})
      |=> $stable(status_out[4:3])) else $error("reset-cause flags changed");
   // The address register takes the bank bits written in the same cycle.
   AST_DIRECT: assert property (1'b1 |=> direct_addr ==
      {status_out[6:5], $past(direct_offset)})
      else $error("direct address wrong");
   AST_CLEAR_STATUS: assert property (
      instr.valid && instr.op == OP_CLR && instr.dest_file
      && instr.file_addr[6:0] == 7'h03
      |=> status_out[7:5] == 3'h0 && status_out[2])
      else $error("file clear of status wrong");
   AST_INDIRECT: assert property (1'b1 |=> indirect_addr ==
      {status_out[7], $past(indirect_pointer)})
      else $error("indirect address wrong");
   AST_ZERO: assert property (
      instr.valid && instr.op inside {OP_ADD, OP_SUB, OP_CLR}
      |=> status_out[2] == (rsp.data == 8'h00)) else $error("zero flag wrong");
   AST_CARRY: assert property (
      instr.valid && instr.op inside {OP_ADD, OP_SUB}
      |=> status_out[1:0] == {$past(nib5[4]), $past(sum9[8])})
      else $error("carry flags wrong");
   AST_ROTATE: assert property (
      instr.valid && instr.op inside {OP_ROTATE_RIGHT, OP_ROTATE_LEFT}
      |=> status_out[0] == $past(rot_out)) else $error("rotate carry wrong");
endmodule : core_status_flag_register_props

bind core_status_flag_register core_status_flag_register_props
   #(.ADDR_W(ADDR_W)) props_inst (.mclk, .sys_rst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .instr, .watchdog_timeout, .direct_offset,
   .indirect_pointer, .rsp, .status_out, .direct_addr, .indirect_addr, .irq);

// file: tb/core_status_flag_register_tb.sv
// Self-checking testbench for the core status flag register.
module core_status_flag_register_tb
   import core_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest, irq;
   logic watchdog_timeout;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, bus_rdata;
   logic [7:0] status_out, indirect_pointer;
   logic [6:0] direct_offset;
   logic [8:0] direct_addr, indirect_addr;
   instr_req_t instr;
   instr_rsp_t rsp;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   core_status_flag_register core_status_flag_register_inst (.mclk, .sys_rst,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .instr, .watchdog_timeout,
      .direct_offset, .indirect_pointer, .rsp, .status_out, .direct_addr,
      .indirect_addr, .irq);
   core_exec_model core_exec_model_inst (.mclk, .instr);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   // The whole run needs well under a thousand cycles.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e,
         input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Waitrequest and read data are taken at the same rising edge, before
   // that edge's own updates land; only then is the request dropped.
   task automatic bus_op(input logic wr, input logic [3:0] a,
         input logic [7:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      bus_rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus_op
   task automatic t_regs();
      bus_op(1'b0, 4'h3, 8'h00);
      chk("status reset", 16'h0018, bus_rdata[15:0]);
      chk("irq reset", 16'h0000, 16'(irq));
      bus_op(1'b0, 4'hF, 8'h00);
      chk("unmapped read", 16'h0000, bus_rdata[15:0]);
      bus_op(1'b1, 4'h3, 8'h00);
      bus_op(1'b0, 4'h3, 8'h00);
      chk("status write 00", 16'h0018, bus_rdata[15:0]);
      bus_op(1'b1, 4'h3, 8'hA5);
      bus_op(1'b0, 4'h3, 8'h00);
      chk("status write A5", 16'h00BD, bus_rdata[15:0]);
      avs_byteenable <= 4'hE;
      bus_op(1'b1, 4'h3, 8'h00);
      avs_byteenable <= 4'hF;
      bus_op(1'b0, 4'h3, 8'h00);
      chk("masked write", 16'h00BD, bus_rdata[15:0]);
      $display("test regs done");
   endtask : t_regs
   task automatic t_instr();
      core_exec_model_inst.issue(OP_CLR, 8'hBD, 8'h00, 3'h0, 1'b1, 9'h083);
      chk("clear status", 16'h001D, 16'(status_out));
      core_exec_model_inst.issue(OP_BIT_SET, 8'h1D, 8'h00, 3'h5, 1'b1,
         9'h183);
      chk("bit set status", 16'h003D, 16'(status_out));
      core_exec_model_inst.issue(OP_ADD, 8'h0F, 8'h01, 3'h0, 1'b1, 9'h103);
      chk("add to status", 16'h001A, 16'(status_out));
      chk("add result", 16'h0010, 16'(rsp.data));
      chk("add valid", 16'h0001, 16'(rsp.valid));
      core_exec_model_inst.issue(OP_SUB, 8'h05, 8'h05, 3'h0, 1'b0, 9'h020);
      chk("sub equal", 16'h001F, 16'(status_out));
      core_exec_model_inst.issue(OP_SUB, 8'h00, 8'h01, 3'h0, 1'b0, 9'h020);
      chk("sub borrow", 16'h0018, 16'(status_out));
      core_exec_model_inst.issue(OP_ROTATE_RIGHT, 8'h01, 8'h00, 3'h0, 1'b0,
         9'h020);
      chk("rotate right", 16'h0019, 16'(status_out));
      core_exec_model_inst.issue(OP_ROTATE_LEFT, 8'h7F, 8'h00, 3'h0, 1'b0,
         9'h020);
      chk("rotate left", 16'h0018, 16'(status_out));
      bus_op(1'b0, 4'h6, 8'h00);
      chk("last result", 16'h00FF, bus_rdata[15:0]);
      $display("test instr done");
   endtask : t_instr
   task automatic t_events();
      bus_op(1'b1, 4'h5, 8'h01);
      core_exec_model_inst.issue(OP_SLEEP, 8'h00, 8'h00, 3'h0, 1'b0, 9'h020);
      chk("sleep flags", 16'h0010, 16'(status_out));
      @(posedge mclk);
      watchdog_timeout <= 1'b1;
      @(posedge mclk);
      watchdog_timeout <= 1'b0;
      @(negedge mclk);
      chk("time-out flags", 16'h0000, 16'(status_out));
      chk("irq raised", 16'h0001, 16'(irq));
      bus_op(1'b0, 4'h4, 8'h00);
      chk("irq status", 16'h000B, bus_rdata[15:0]);
      repeat (2) @(negedge mclk);
      chk("irq cleared", 16'h0000, 16'(irq));
      core_exec_model_inst.issue(OP_WATCHDOG_CLEAR, 8'h00, 8'h00, 3'h0, 1'b0,
         9'h020);
      chk("watchdog clear", 16'h0018, 16'(status_out));
      $display("test events done");
   endtask : t_events
   task automatic t_addr();
      bus_op(1'b1, 4'h3, 8'h60);
      direct_offset <= 7'h7F;
      indirect_pointer <= 8'hAB;
      repeat (2) @(negedge mclk);
      chk("direct bank 3", 16'h01FF, 16'(direct_addr));
      chk("indirect low", 16'h00AB, 16'(indirect_addr));
      bus_op(1'b1, 4'h3, 8'h80);
      repeat (2) @(negedge mclk);
      chk("direct bank 0", 16'h007F, 16'(direct_addr));
      chk("indirect high", 16'h01AB, 16'(indirect_addr));
      $display("test addr done");
   endtask : t_addr
   initial begin
      sys_rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      watchdog_timeout = 1'b0;
      direct_offset = 7'h00;
      indirect_pointer = 8'h00;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      t_regs();
      t_instr();
      t_events();
      t_addr();
      end_sim();
   end
endmodule : core_status_flag_register_tb
